// [sesa_defs.svh]
// constants shared by the serial memory slave and its bus controller
`ifndef SESA_DEFS_SVH
`define SESA_DEFS_SVH
`define SESA_CLK_NS 20
`define SESA_TWC_NS 5000000
`define SESA_TWC_CYC (`SESA_TWC_NS / `SESA_CLK_NS)
`define SESA_SCL_NS 10000
`define SESA_QTR_CYC (`SESA_SCL_NS / 4 / `SESA_CLK_NS)
// device type code: arbitrary value
`define SESA_TYPE_CODE 4'h5
`define SESA_OFF_CTRL 8'h00
`define SESA_OFF_ADDR 8'h04
`define SESA_OFF_DATA 8'h08
`define SESA_OFF_STAT 8'h0c
`define SESA_CTRL_OP_LSB 0
`define SESA_CTRL_SEL_LSB 2
`define SESA_STAT_BUSY 0
`define SESA_STAT_NACK 1
`endif

// [sesa_pkg.sv]
// types of the serial memory slave and its bus controller
package sesa_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_RX = 3'b001, DS_ACK = 3'b010,
    DS_TX = 3'b011, DS_TXACK = 3'b100, DS_IGN = 3'b101
  } sesa_dstate_e;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00, MS_START = 2'b01, MS_BITS = 2'b10, MS_STOP = 2'b11
  } sesa_mstate_e;
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00, OP_SETADDR = 2'b01, OP_READ = 2'b10
  } sesa_op_e;
  typedef struct packed {
    sesa_dstate_e st;
    logic scl_a, scl_b, scl_c;
    logic sda_a, sda_b, sda_c;
    logic [2:0] sel_a, sel_b;
    logic wp_a, wp_b;
    logic [7:0] sh;
    logic [2:0] bitc;
    logic full;
    logic [1:0] byte_n;
    logic rw, mack, wrote;
    logic [5:0] ahi;
    logic [13:0] ptr;
    logic [23:0] bcnt;
    logic busy;
    logic sda_oe, sda_o;
    logic wr_valid;
    logic [13:0] wr_addr;
    logic [7:0] wr_data;
  } sesa_dev_s;
  typedef struct packed {
    sesa_mstate_e st;
    logic [1:0] q;
    logic [15:0] qc;
    logic [1:0] bi;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic scl_oe, scl_o, sda_oe, sda_o;
    logic sda_a, sda_b;
    sesa_op_e op;
    logic [2:0] sel;
    logic [13:0] addr;
    logic [7:0] wdata, rdata;
    logic nack, busy;
    logic wr_pend;
    logic [7:0] wr_off;
    logic [31:0] hrdata;
    logic hreadyout, hresp;
  } sesa_mst_s;
endpackage

// [sesa_link_if.sv]
// two-wire link between the controller and the memory slave
interface sesa_link_if;
  logic scl_oe, scl_o;
  logic sda_m_oe, sda_m_o;
  logic sda_d_oe, sda_d_o;
  logic scl, sda;
  // open drain: only a low drive counts, pull-ups give the high level
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_d_oe & ~sda_d_o));
  modport master (output scl_oe, output scl_o, output sda_m_oe, output sda_m_o, input sda);
  modport device (output sda_d_oe, output sda_d_o, input scl, input sda);
endinterface

// [sesa_device.sv]
// serial memory slave front end: conditions, control byte, word address
// Functional notes
// [RQ1] sda falling with scl high is Start
// [RQ2] sda rising with scl high is Stop
// [RQ3] master opens each command with Start
// [RQ4] master closes each operation with Stop
// [RQ5] one bit per clock, stable while high
// [RQ6] idle means both lines high
// [RQ7] receiver acknowledges every byte on ninth clock
// [RQ8] acknowledge holds sda low whole high time
// [RQ9] unacked last read byte, device releases sda
// [RQ10] first byte is control, type code checked
// [RQ11] three select bits must match select pins
// [RQ12] matching control byte acknowledged, then read/write
// [RQ13] last control bit: one read, zero write
// [RQ14] two address bytes, high first, 14 bits
// [RQ15] device only pulls sda low or releases
// [RQ16] write protect high inhibits writes only
// [RQ17] select levels settled before bus use
// [RQ18] reduced package: low selects read as zero
// [RQ19] master uses selects as upper address
// [RQ20] master makes clock, Start and Stop
// [RQ21] master chooses byte count per transfer
// [RQ22] no acknowledge during internal write cycle
// [RQ23] address bytes load the address pointer
// [RQ24] mismatch: stay released until next Start
`include "sesa_defs.svh"
module sesa_device #(
  parameter logic [3:0] TYPE_CODE = `SESA_TYPE_CODE,
  parameter bit REDUCED_PIN = 1'b0,
  parameter int unsigned WRITE_CYCLES = `SESA_TWC_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  sesa_link_if.device link,
  input wire logic select_pin_low,
  input wire logic select_pin_mid,
  input wire logic select_pin_high,
  input wire logic write_protect,
  input wire logic [7:0] rd_data,
  output logic [13:0] addr_ptr,
  output logic wr_valid,
  output logic [13:0] wr_addr,
  output logic [7:0] wr_data,
  output logic write_busy
);
  import sesa_pkg::*;

  sesa_dev_s r, n;
  logic rise, fall, start, stop;
  logic [2:0] exp_sel;
  logic hit;

  function automatic logic [13:0] next_ptr(input logic [13:0] p);
    return p + 14'h1;
  endfunction

  assign rise = r.scl_b & ~r.scl_c;
  assign fall = ~r.scl_b & r.scl_c;
  assign start = r.scl_b & r.scl_c & r.sda_c & ~r.sda_b; // [RQ1]
  assign stop = r.scl_b & r.scl_c & ~r.sda_c & r.sda_b; // [RQ2]
  // absent pins of the small package compare as zero
  assign exp_sel = {r.sel_b[2], REDUCED_PIN ? 2'h0 : r.sel_b[1:0]}; // [RQ18]
  // a busy write cycle withholds even the control byte acknowledge
  assign hit = (r.sh[7:4] == TYPE_CODE) && (r.sh[3:1] == exp_sel) && !r.busy; // [RQ10] [RQ11] [RQ22]

  always_comb begin
    n = r;
    n.scl_a = link.scl;
    n.scl_b = r.scl_a;
    n.scl_c = r.scl_b;
    n.sda_a = link.sda;
    n.sda_b = r.sda_a;
    n.sda_c = r.sda_b;
    n.sel_a = {select_pin_high, select_pin_mid, select_pin_low};
    n.sel_b = r.sel_a;
    n.wp_a = write_protect;
    n.wp_b = r.wp_a;
    n.sda_o = 1'b0; // [RQ15]
    n.wr_valid = 1'b0;
    if (r.bcnt != 24'h0) begin
      n.bcnt = r.bcnt - 24'h1;
    end
    if (start) begin
      n.st = DS_RX; // [RQ1]
      n.bitc = 3'h0;
      n.full = 1'b0;
      n.byte_n = 2'h0;
      n.sda_oe = 1'b0;
    end else if (stop) begin
      n.st = DS_IDLE; // [RQ2]
      n.sda_oe = 1'b0;
      n.wrote = 1'b0;
      // protect level taken at Stop decides the write cycle
      if (r.wrote && !r.wp_b) begin
        n.bcnt = WRITE_CYCLES[23:0]; // [RQ16] [RQ22]
      end
    end else begin
      unique case (r.st)
        DS_IDLE, DS_IGN: begin
          n.sda_oe = 1'b0; // [RQ24]
        end
        DS_RX: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda_b}; // [RQ5]
            n.bitc = r.bitc + 3'h1;
            n.full = (r.bitc == 3'h7);
          end else if (fall && r.full) begin
            n.full = 1'b0;
            n.st = DS_ACK;
            n.sda_oe = 1'b1; // [RQ7] [RQ8]
            unique case (r.byte_n)
              2'h0: begin
                n.rw = r.sh[0]; // [RQ13]
                if (!hit) begin
                  n.st = DS_IGN; // [RQ24]
                  n.sda_oe = 1'b0;
                end
              end
              2'h1: n.ahi = r.sh[5:0]; // [RQ14]
              2'h2: n.ptr = {r.ahi, r.sh}; // [RQ14] [RQ23]
              2'h3: begin
                // protected writes are acknowledged but never stored
                if (!r.wp_b) begin
                  n.wr_valid = 1'b1; // [RQ16]
                  n.wr_addr = r.ptr;
                  n.wr_data = r.sh;
                  n.wrote = 1'b1;
                end
                n.ptr = next_ptr(r.ptr);
              end
            endcase
          end
        end
        DS_ACK: begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.bitc = 3'h0;
            if (r.byte_n == 2'h0 && r.rw) begin
              n.st = DS_TX; // [RQ12] [RQ13]
              n.sh = rd_data;
              n.sda_oe = ~rd_data[7]; // [RQ15]
            end else begin
              n.st = DS_RX; // [RQ12] [RQ21]
              if (r.byte_n != 2'h3) begin
                n.byte_n = r.byte_n + 2'h1;
              end
            end
          end
        end
        DS_TX: begin
          if (fall) begin
            if (r.bitc == 3'h7) begin
              n.sda_oe = 1'b0;
              n.st = DS_TXACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_oe = ~r.sh[6]; // [RQ5] [RQ15]
              n.bitc = r.bitc + 3'h1;
            end
          end
        end
        DS_TXACK: begin
          if (rise) begin
            n.mack = ~r.sda_b;
            n.ptr = next_ptr(r.ptr);
          end else if (fall) begin
            if (r.mack) begin
              n.st = DS_TX; // [RQ21]
              n.sh = rd_data;
              n.sda_oe = ~rd_data[7];
              n.bitc = 3'h0;
            end else begin
              n.st = DS_IGN; // [RQ9]
              n.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          n.st = DS_IDLE;
          n.sda_oe = 1'b0;
        end
      endcase
    end
    n.busy = (n.bcnt != 24'h0);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.scl_a <= 1'b1;
      r.scl_b <= 1'b1;
      r.scl_c <= 1'b1;
      r.sda_a <= 1'b1;
      r.sda_b <= 1'b1;
      r.sda_c <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.sda_d_oe = r.sda_oe;
  assign link.sda_d_o = r.sda_o;
  assign addr_ptr = r.ptr;
  assign wr_valid = r.wr_valid;
  assign wr_addr = r.wr_addr;
  assign wr_data = r.wr_data;
  assign write_busy = r.busy;
endmodule

// [sesa_master.sv]
// bus controller: register slave on the system bus driving the two-wire link
`include "sesa_defs.svh"
module sesa_master #(
  parameter logic [3:0] TYPE_CODE = `SESA_TYPE_CODE,
  parameter int unsigned QTR_CYCLES = `SESA_QTR_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  sesa_link_if.master link
);
  import sesa_pkg::*;

  sesa_mst_s r, n;
  logic tick, rx;

  function automatic logic [7:0] byte_of(input logic [1:0] idx, input sesa_mst_s s);
    logic [7:0] b;
    unique case (idx)
      2'h0: b = {TYPE_CODE, s.sel, s.op == OP_READ};
      2'h1: b = {2'h0, s.addr[13:8]};
      2'h2: b = s.addr[7:0];
      2'h3: b = s.wdata;
    endcase
    return b;
  endfunction

  function automatic logic [1:0] last_of(input sesa_op_e op);
    logic [1:0] l;
    unique case (op)
      OP_WRITE: l = 2'h3;
      OP_SETADDR: l = 2'h2;
      OP_READ: l = 2'h1;
      default: l = 2'h0;
    endcase
    return l;
  endfunction

  assign tick = (r.qc == 16'(QTR_CYCLES - 1));
  assign rx = (r.op == OP_READ) && (r.bi == 2'h1);

  always_comb begin
    n = r;
    n.sda_a = link.sda;
    n.sda_b = r.sda_a;
    n.qc = tick ? 16'h0 : r.qc + 16'h1;
    n.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      n.wr_pend = hwrite;
      n.wr_off = haddr[7:0];
      n.hrdata = 32'h0;
      if (!hwrite) begin
        case (haddr[7:0])
          `SESA_OFF_CTRL: begin
            n.hrdata[`SESA_CTRL_OP_LSB +: 2] = r.op;
            n.hrdata[`SESA_CTRL_SEL_LSB +: 3] = r.sel;
          end
          `SESA_OFF_ADDR: n.hrdata[13:0] = r.addr;
          `SESA_OFF_DATA: n.hrdata[7:0] = r.rdata;
          `SESA_OFF_STAT: begin
            n.hrdata[`SESA_STAT_BUSY] = r.busy;
            n.hrdata[`SESA_STAT_NACK] = r.nack;
          end
          default: n.hrdata = 32'h0;
        endcase
      end
    end
    // settings are frozen while a frame runs so it stays consistent
    if (r.wr_pend && !r.busy) begin
      case (r.wr_off)
        `SESA_OFF_CTRL: begin
          if (hwdata[`SESA_CTRL_OP_LSB +: 2] != 2'h3) begin
            n.op = sesa_op_e'(hwdata[`SESA_CTRL_OP_LSB +: 2]);
            n.sel = hwdata[`SESA_CTRL_SEL_LSB +: 3]; // [RQ19]
            n.busy = 1'b1;
            n.nack = 1'b0;
          end
        end
        `SESA_OFF_ADDR: n.addr = hwdata[13:0];
        `SESA_OFF_DATA: n.wdata = hwdata[7:0];
        default: n.busy = r.busy;
      endcase
    end
    unique case (r.st)
      MS_IDLE: begin
        n.q = 2'h0;
        if (r.busy && r.sda_b) begin
          n.st = MS_START; // [RQ3] [RQ6]
        end
      end
      MS_START: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          if (r.q == 2'h1) begin
            n.sda_oe = 1'b1; // [RQ1] [RQ20]
          end
          if (r.q == 2'h3) begin
            n.scl_oe = 1'b1;
            n.st = MS_BITS;
            n.bi = 2'h0;
            n.bitn = 4'h0;
            n.sh = byte_of(2'h0, r);
          end
        end
      end
      MS_BITS: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          unique case (r.q)
            // data moves only a quarter after scl fell
            2'h0: n.sda_oe = (r.bitn < 4'h8) && !rx && !r.sh[7]; // [RQ5] [RQ9]
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.scl_oe = 1'b0;
            2'h3: begin
              n.scl_oe = 1'b1;
              if (r.bitn < 4'h8) begin
                n.sh = {r.sh[6:0], r.sda_b};
                n.bitn = r.bitn + 4'h1;
              end else if (rx) begin
                n.rdata = r.sh; // [RQ9]
                n.st = MS_STOP;
              end else if (r.sda_b) begin
                n.nack = 1'b1; // [RQ7]
                n.st = MS_STOP;
              end else if (r.bi == last_of(r.op)) begin
                n.st = MS_STOP; // [RQ4] [RQ21]
              end else begin
                n.bi = r.bi + 2'h1;
                n.bitn = 4'h0;
                n.sh = byte_of(r.bi + 2'h1, r); // [RQ14]
              end
            end
          endcase
        end
      end
      MS_STOP: begin
        if (tick) begin
          n.q = r.q + 2'h1;
          unique case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.scl_oe = 1'b0;
            2'h3: begin
              n.sda_oe = 1'b0; // [RQ2] [RQ4]
              n.st = MS_IDLE;
              n.busy = 1'b0;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.sda_a <= 1'b1;
      r.sda_b <= 1'b1;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = r.hreadyout;
  assign hrdata = r.hrdata;
  assign hresp = r.hresp;
  assign link.scl_oe = r.scl_oe;
  assign link.scl_o = r.scl_o;
  assign link.sda_m_oe = r.sda_oe;
  assign link.sda_m_o = r.sda_o;
endmodule

// [sesa_link_assertions.sv]
// concurrent checks on the two-wire link between controller and slave
module sesa_link_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl_oe,
  input wire logic scl_o,
  input wire logic sda_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_d_oe,
  input wire logic sda_d_o,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $rose(sda);
  endsequence
  a_sda_pull_only: assert property (sda_d_oe |-> !sda_d_o)
    else $error("slave drives sda high");
  a_master_pull_only: assert property ((scl_oe |-> !scl_o) and (sda_m_oe |-> !sda_m_o))
    else $error("controller drives a line high");
  a_slave_change_low: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl, 2))
    else $error("slave moved sda near or during clock high");
  a_start_from_idle: assert property (start_s |-> $past(sda, 2) && $past(scl, 2))
    else $error("start issued on a busy bus");
  a_start_hold: assert property (start_s |=> scl [*4])
    else $error("clock dropped too soon after start");
  a_ack_stands: assert property ($rose(scl) && sda_d_oe |=> (sda_d_oe && !sda) [*8])
    else $error("slave low level not held through clock high");
  a_stop_release: assert property (stop_s |-> !sda_d_oe [*8])
    else $error("slave holds sda after stop");
  a_scl_low_len: assert property ($fell(scl) |=> !scl [*8])
    else $error("clock low phase too short");
endmodule

// [sesa_tb.sv]
// self-checking bench: bus controller and memory slave joined over the link
module sesa_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic wp = 1'b0;
  logic rdph = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  // straps settle from time zero, long before the first frame
  logic [2:0] pins = 3'h5;
  logic [15:0] rs = 16'h0058;
  logic hreadyout, hresp, wr_valid, write_busy;
  logic [31:0] hrdata, r;
  logic [13:0] addr_ptr, wr_addr;
  logic [7:0] wr_data, rd_data;
  logic [32:0] e;
  logic [32:0] rq[$];
  logic [21:0] wq[$];
  int errors = 0;
  int cmp_count = 0;
  sesa_link_if link ();
  // memory stand-in: each address returns a byte derived from itself
  assign rd_data = addr_ptr[7:0] ^ 8'ha5;
  always #10 hclk = ~hclk;
  sesa_master #(.QTR_CYCLES(8)) i_sesa_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(link));
  // write cycle long enough that a polling frame lands inside it
  sesa_device #(.WRITE_CYCLES(1000)) i_sesa_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .select_pin_low(pins[0]), .select_pin_mid(pins[1]), .select_pin_high(pins[2]),
    .write_protect(wp), .rd_data(rd_data), .addr_ptr(addr_ptr), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .write_busy(write_busy));
  // small-package slave on a mirrored link: its low straps are high, yet only select 000 may wake it
  sesa_link_if link_rp ();
  logic [13:0] ptr_rp;
  logic oe_rp_q = 1'b0;
  int acks_rp = 0;
  assign link_rp.scl_oe = link.scl_oe;
  assign link_rp.scl_o = link.scl_o;
  assign link_rp.sda_m_oe = link.sda_m_oe;
  assign link_rp.sda_m_o = link.sda_m_o;
  sesa_device #(.REDUCED_PIN(1'b1), .WRITE_CYCLES(1000)) i_sesa_device_rp (.hclk(hclk), .hresetn(hresetn),
    .link(link_rp), .select_pin_low(1'b1), .select_pin_mid(1'b1), .select_pin_high(1'b0),
    .write_protect(wp), .rd_data(8'h00), .addr_ptr(ptr_rp), .wr_valid(), .wr_addr(), .wr_data(),
    .write_busy());
  always @(posedge hclk) begin
    oe_rp_q <= link_rp.sda_d_oe;
    if (link_rp.sda_d_oe === 1'b1 && oe_rp_q === 1'b0) acks_rp <= acks_rp + 1;
  end
  sesa_link_assertions i_sesa_link_assertions (.hclk(hclk), .hresetn(hresetn),
    .scl_oe(link.scl_oe), .scl_o(link.scl_o), .sda_m_oe(link.sda_m_oe), .sda_m_o(link.sda_m_o),
    .sda_d_oe(link.sda_d_oe), .sda_d_o(link.sda_d_o), .scl(link.scl), .sda(link.sda));
  function automatic logic [15:0] lf(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic lim(input logic ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    lim(hreadyout === 1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic c, input logic [31:0] x, output logic [31:0] q);
    rq.push_back({c, x});
    bus(1'b0, a, 32'h0, q);
  endtask
  // start a frame, poll until it ends, then compare status
  task automatic go(input logic [1:0] op, input logic [2:0] s, input logic [31:0] st);
    int n;
    logic [31:0] q;
    bus(1'b1, 8'h00, {27'h0, s, op}, q);
    @(posedge hclk);
    n = 0;
    do begin
      rd(8'h0c, 1'b0, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    lim(q[0] === 1'b0);
    rd(8'h0c, 1'b1, st, q);
  endtask
  task automatic wbyte(input logic [15:0] a, input logic [7:0] d, input logic [31:0] st);
    logic [31:0] q;
    bus(1'b1, 8'h04, {16'h0, a}, q);
    bus(1'b1, 8'h08, {24'h0, d}, q);
    go(2'h0, 3'h5, st);
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (write_busy !== 1'b0 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    lim(write_busy === 1'b0);
  endtask
  always @(posedge hclk) begin
    if (rdph) begin
      e = rq.pop_front();
      if (e[32]) chk(hrdata, e[31:0]);
    end
    if (wr_valid === 1'b1) begin
      if (wq.size() == 0) chk(32'h1, 32'h0);
      else chk({10'h0, wr_addr, wr_data}, {10'h0, wq.pop_front()});
    end
    rdph <= hsel & htrans[1] & ~hwrite;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({14'h0, addr_ptr, write_busy, wr_valid, hresp, hreadyout}, 32'h1);
    repeat (4) @(posedge hclk);
    rd(8'h10, 1'b1, 32'h0, r);
    $display("end reset");
    for (int i = 0; i < 2; i++) begin
      rs = lf(rs);
      wq.push_back({rs[13:0], rs[15:8]});
      wbyte(rs, rs[15:8], 32'h0);
      chk({18'h0, addr_ptr}, {18'h0, rs[13:0] + 14'h1});
      go(2'h0, 3'h5, 32'h2);
      idle();
    end
    $display("end writes");
    wp <= 1'b1;
    wbyte(16'h1234, 8'h77, 32'h0);
    repeat (8) @(posedge hclk);
    chk({31'h0, write_busy}, 32'h0);
    // protect stays high: addressing and reads must still go through
    $display("end protect");
    bus(1'b1, 8'h04, {16'h0, rs}, r);
    for (int s = 0; s < 8; s++) begin
      go(2'h1, s[2:0], (s == 5) ? 32'h0 : 32'h2);
    end
    chk({18'h0, addr_ptr}, {18'h0, rs[13:0]});
    chk(32'(acks_rp), 32'h1);
    $display("end select");
    for (int i = 0; i < 2; i++) begin
      go(2'h2, 3'h5, 32'h0);
      rd(8'h08, 1'b1, {24'h0, rs[7:0] + i[7:0] ^ 8'ha5}, r);
    end
    chk({18'h0, addr_ptr}, {18'h0, rs[13:0] + 14'h2});
    chk(32'(wq.size()), 32'h0);
    $display("end reads");
    // op 3 is refused, so the last read setting must read back
    bus(1'b1, 8'h00, 32'h1f, r);
    rd(8'h00, 1'b1, 32'h16, r);
    rd(8'h04, 1'b1, {18'h0, rs[13:0]}, r);
    rd(8'h0c, 1'b1, 32'h0, r);
    // let the monitor take the last data phase before the verdict
    repeat (2) @(posedge hclk);
    $display("end registers");
    wrap_up();
  end
endmodule
